/* include/gcr_pkg.sv */
package gcr_pkg;
   // ***************************************
   // Widths
   // ***************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CW     = 16;

   // ***************************************
   // Register map
   // ***************************************
   localparam logic [7:0] OFF_CFG     = 8'h00;
   localparam logic [7:0] OFF_PRESET  = 8'h04;
   localparam logic [7:0] OFF_CAPTURE = 8'h08;
   localparam logic [7:0] OFF_COUNT   = 8'h0c;
   localparam logic [7:0] OFF_CMD     = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;

   // ***************************************
   // Configuration word fields
   // ***************************************
   localparam logic [15:0] CFG_RST     = 16'h0800;
   localparam int          CF_OUT_LSB  = 0;
   localparam int          CF_UP       = 3;
   localparam int          CF_BCD      = 4;
   localparam int          CF_REPEAT   = 5;
   localparam int          CF_SPECIAL  = 7;
   localparam int          CF_SRC_LSB  = 8;
   localparam int          CF_POL      = 12;
   localparam int          CF_GATE_LSB = 13;

   localparam logic [2:0] OUT_LOW    = 3'h0;
   localparam logic [2:0] OUT_TC_HI  = 3'h1;
   localparam logic [2:0] OUT_FLIP   = 3'h2;
   localparam logic [2:0] OUT_HIZ    = 3'h4;
   localparam logic [2:0] OUT_TC_LO  = 3'h5;

   localparam logic [3:0] SRC_FREQ1  = 4'h8;
   localparam logic [2:0] GATE_NONE  = 3'h0;
   localparam logic [2:0] GATE_LEVEL = 3'h5;
   localparam logic [2:0] GATE_EDGE  = 3'h6;

   // ***************************************
   // Command bits and terminal values
   // ***************************************
   localparam int CMD_ARM    = 0;
   localparam int CMD_DISARM = 1;
   localparam int CMD_LOAD   = 2;
   localparam int CMD_SET    = 3;
   localparam int CMD_CLR    = 4;
   localparam int CMD_MRESET = 5;

   localparam logic [15:0] TERM_DOWN = 16'h0001;
   localparam logic [15:0] TERM_BCD  = 16'h9999;
   localparam logic [15:0] TERM_BIN  = 16'hffff;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MD_FREE, MD_LEVEL, MD_EDGE_RETRIG, MD_EDGE_SAVE, MD_GATE_SEL
   } gcr_mode_t;
endpackage

/* rtl/gcr_step.sv */
`timescale 1ns/1ps
module gcr_step #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] cnt,
   input  wire logic         up,
   input  wire logic         bcd,
   output logic      [W-1:0] nxt,
   output logic              at_term
);
   import gcr_pkg::*;

   logic [W/4:0]   carry;
   logic [W-1:0]   bcd_nxt;
   logic [W-1:0]   bin_nxt;

   assign carry[0] = 1'b1;

   // ***************************************
   // Per-digit decimal step
   // ***************************************
   genvar g;
   generate
      for (g = 0; g < W/4; g++) begin : g_dig
         wire logic [3:0] d = cnt[4*g+3:4*g];
         wire logic       wrap = up ? (d == 4'h9) : (d == 4'h0);
         assign bcd_nxt[4*g+3:4*g] = !carry[g] ? d :
                                     wrap ? (up ? 4'h0 : 4'h9) :
                                     up ? d + 4'h1 : d - 4'h1;
         assign carry[g+1] = carry[g] && wrap;
      end
   endgenerate

   assign bin_nxt = up ? cnt + {{(W-1){1'b0}}, 1'b1} : cnt - {{(W-1){1'b0}}, 1'b1};
   assign nxt     = bcd ? bcd_nxt : bin_nxt;
   // Expiry is judged one count ahead
   assign at_term = !up ? (cnt == TERM_DOWN[W-1:0]) :
                    bcd ? (cnt == TERM_BCD[W-1:0]) : (cnt == TERM_BIN[W-1:0]);
endmodule

/* rtl/gcr_counter.sv */
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module gcr_counter (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [gcr_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [gcr_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [gcr_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [gcr_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        first_prescaled_freq,
   input  wire logic                        src_pin,
   input  wire logic                        gate_pin,
   output logic                             count_out,
   output logic                             count_out_oe
);
   import gcr_pkg::*;

   // ***************************************
   // Bus slave state
   // ***************************************
   logic              awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
   logic              aw_full_r, w_full_r;
   logic [ADDR_W-1:0] wr_addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [3:0]        wstrb_r;
   logic [1:0]        bresp_r, rresp_r;
   logic [DATA_W-1:0] rdata_r;

   // ***************************************
   // Counter state
   // ***************************************
   logic [CW-1:0] cfg_r, preset_r, capture_r, cnt_r;
   logic          armed_r, run_r, pend_r, second_r, tc_r, flip_r;
   logic          src_prev_r, gate_prev_r, out_r, oe_r;

   wire logic          aw_take  = s_axi_awvalid && awready_r;
   wire logic          w_take   = s_axi_wvalid && wready_r;
   wire logic          ar_take  = s_axi_arvalid && arready_r;
   wire logic          wr_fire  = aw_full_r && w_full_r && !bvalid_r;
   wire logic          hit_cfg  = wr_addr_r == OFF_CFG;
   wire logic          hit_pre  = wr_addr_r == OFF_PRESET;
   wire logic          hit_cap  = wr_addr_r == OFF_CAPTURE;
   wire logic          hit_cmd  = wr_addr_r == OFF_CMD;
   wire logic          wr_known = hit_cfg || hit_pre || hit_cap || hit_cmd;
   wire logic [CW-1:0] wmask    = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire logic [CW-1:0] wval     = wdata_r[CW-1:0] & wmask;
   wire logic          cmd_fire = wr_fire && hit_cmd && wstrb_r[0];
   wire logic          cmd_arm  = cmd_fire && wdata_r[CMD_ARM];
   wire logic          cmd_dis  = cmd_fire && wdata_r[CMD_DISARM];
   wire logic          cmd_load = cmd_fire && wdata_r[CMD_LOAD];
   wire logic          cmd_set  = cmd_fire && wdata_r[CMD_SET];
   wire logic          cmd_clr  = cmd_fire && wdata_r[CMD_CLR];
   wire logic          cmd_mrst = cmd_fire && wdata_r[CMD_MRESET];

   // ***************************************
   // Read decode
   // ***************************************
   wire logic          rd_known = s_axi_araddr == OFF_CFG || s_axi_araddr == OFF_PRESET ||
                                  s_axi_araddr == OFF_CAPTURE || s_axi_araddr == OFF_COUNT ||
                                  s_axi_araddr == OFF_STATUS || s_axi_araddr == OFF_CMD;
   wire logic [CW-1:0] status   = {10'h000, flip_r, tc_r, second_r, pend_r, run_r, armed_r};
   wire logic [CW-1:0] rd_mux   = s_axi_araddr == OFF_CFG     ? cfg_r :
                                  s_axi_araddr == OFF_PRESET  ? preset_r :
                                  s_axi_araddr == OFF_CAPTURE ? capture_r :
                                  s_axi_araddr == OFF_COUNT   ? cnt_r :
                                  s_axi_araddr == OFF_STATUS  ? status : 16'h0000;

   // ***************************************
   // Mode decode
   // ***************************************
   wire logic [2:0] gating = cfg_r[CF_GATE_LSB+2:CF_GATE_LSB];
   wire logic       special = cfg_r[CF_SPECIAL];
   wire logic       repeat_on = cfg_r[CF_REPEAT];
   wire gcr_mode_t  mode = gating == GATE_NONE  ? (special ? MD_GATE_SEL : MD_FREE) :
                           gating == GATE_LEVEL ? MD_LEVEL :
                           gating == GATE_EDGE  ? (special ? MD_EDGE_RETRIG : MD_EDGE_SAVE) : MD_FREE;
   wire logic       edge_md = mode == MD_EDGE_RETRIG || mode == MD_EDGE_SAVE;

   // ***************************************
   // Source and gate events
   // ***************************************
   wire logic src_sel  = cfg_r[CF_SRC_LSB+3:CF_SRC_LSB] == SRC_FREQ1 ? first_prescaled_freq : src_pin;
   wire logic src_lvl  = src_sel ^ cfg_r[CF_POL];
   wire logic src_edge = src_lvl && !src_prev_r;
   wire logic gate_rise = gate_pin && !gate_prev_r;

   // Gate level counts only in level mode; edge modes count once triggered
   wire logic enable = armed_r && (mode == MD_LEVEL ? gate_pin : edge_md ? run_r : 1'b1);
   // An edge ending an expiry is always taken, even disarmed or gated off
   wire logic qual   = src_edge && (tc_r || enable);

   wire logic [CW-1:0] step_nxt;
   wire logic          at_term;
   wire logic [CW-1:0] reload_val = (mode == MD_GATE_SEL && gate_pin) ? capture_r : preset_r;
   wire logic          pend_take  = qual && pend_r && !tc_r;
   wire logic          term_hit   = qual && at_term && !pend_take;
   wire logic          retrig     = armed_r && gate_rise && (mode == MD_EDGE_RETRIG || (mode == MD_LEVEL && special));
   wire logic          save_hit   = armed_r && gate_rise && mode == MD_EDGE_SAVE && run_r;
   wire logic          tc_nxt     = qual ? term_hit : tc_r;
   wire logic          flip_nxt   = cmd_set ? 1'b1 : cmd_clr ? 1'b0 : (qual && tc_r) ? !flip_r : flip_r;
   wire logic [2:0]    out_sel    = cfg_r[CF_OUT_LSB+2:CF_OUT_LSB];
   // Unlisted output codes float the pin rather than guess a level
   wire logic          out_drv    = out_sel == OUT_LOW || out_sel == OUT_TC_HI || out_sel == OUT_TC_LO ||
                                    out_sel == OUT_FLIP;
   wire logic          out_lvl    = out_sel == OUT_TC_HI ? tc_nxt : out_sel == OUT_TC_LO ? !tc_nxt :
                                    out_sel == OUT_FLIP ? flip_nxt : 1'b0;

   gcr_step #(
      .W       (CW)
   ) u_step (
      .cnt     (cnt_r),
      .up      (cfg_r[CF_UP]),
      .bcd     (cfg_r[CF_BCD]),
      .nxt     (step_nxt),
      .at_term (at_term)
   );

   // ***************************************
   // AXI4-Lite write channel
   // ***************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else begin
         awready_r <= s_axi_awvalid && !awready_r && !aw_full_r;
         wready_r  <= s_axi_wvalid && !wready_r && !w_full_r;
         aw_full_r <= aw_take || (aw_full_r && !wr_fire);
         w_full_r  <= w_take || (w_full_r && !wr_fire);
         if (aw_take) begin
            wr_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ***************************************
   // AXI4-Lite read channel
   // ***************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else begin
         arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
         if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {16'h0000, rd_mux};
            rresp_r  <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ***************************************
   // Configuration and preset
   // ***************************************
   // Rewriting the word while armed is not blocked; counting may then misbehave
   always_ff @(posedge aclk) begin
      if (!aresetn || cmd_mrst) begin
         cfg_r <= CFG_RST;
      end else if (wr_fire && hit_cfg) begin
         cfg_r <= (cfg_r & ~wmask) | wval;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         preset_r <= 16'h0000;
      end else if (wr_fire && hit_pre) begin
         preset_r <= (preset_r & ~wmask) | wval;
      end
   end

   // A hardware capture beats a software write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_r <= 16'h0000;
      end else if (retrig || save_hit) begin
         capture_r <= cnt_r;
      end else if (wr_fire && hit_cap) begin
         capture_r <= (capture_r & ~wmask) | wval;
      end
   end

   // ***************************************
   // Count register
   // ***************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 16'h0000;
      end else if (cmd_load) begin
         cnt_r <= reload_val;
      end else if (pend_take) begin
         cnt_r <= preset_r;
      end else if (term_hit) begin
         cnt_r <= reload_val;
      end else if (qual) begin
         cnt_r <= step_nxt;
      end
   end

   // ***************************************
   // Arm, run and retrigger control
   // ***************************************
   always_ff @(posedge aclk) begin
      if (!aresetn || cmd_mrst) begin
         armed_r  <= 1'b0;
         run_r    <= 1'b0;
         pend_r   <= 1'b0;
         second_r <= 1'b0;
      end else begin
         if (cmd_arm) begin
            armed_r  <= 1'b1;
            second_r <= 1'b0;
         end else if (cmd_dis) begin
            armed_r <= 1'b0;
         end else if (term_hit && mode == MD_GATE_SEL && !repeat_on) begin
            armed_r  <= !second_r;
            second_r <= !second_r;
         end else if (term_hit && !edge_md && mode != MD_GATE_SEL && !repeat_on) begin
            armed_r <= 1'b0;
         end
         if (cmd_dis) begin
            run_r <= 1'b0;
         end else if (armed_r && gate_rise && edge_md) begin
            run_r <= 1'b1;
         end else if (term_hit && edge_md) begin
            run_r <= 1'b0;
         end
         if (retrig) begin
            pend_r <= 1'b1;
         end else if (pend_take || cmd_load) begin
            pend_r <= 1'b0;
         end
      end
   end

   // ***************************************
   // Expiry and output stage
   // ***************************************
   // Flip fires on the edge that ends expiry, so a preset of one flips
   // on the second edge after the trigger, or the third after a retrigger, whose first edge loads the preset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_r  <= 1'b0;
         gate_prev_r <= 1'b0;
         tc_r        <= 1'b0;
         flip_r      <= 1'b0;
         out_r       <= 1'b0;
         oe_r        <= 1'b1;
      end else begin
         src_prev_r  <= src_lvl;
         gate_prev_r <= gate_pin;
         tc_r        <= tc_nxt;
         flip_r      <= flip_nxt;
         out_r       <= out_lvl;
         oe_r        <= out_drv;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign count_out     = out_r;
   assign count_out_oe  = oe_r;

   // ***************************************
   // Checks
   // ***************************************
   disarmed_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == MD_LEVEL && !armed_r && !tc_r && !cmd_load) |=> cnt_r == $past(cnt_r))
      else $error("count moved while disarmed");
   gate_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == MD_LEVEL && !gate_pin && !tc_r && !cmd_load) |=> cnt_r == $past(cnt_r))
      else $error("count moved with gate inactive");
   expiry_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (term_hit && !cmd_load) |=> (cnt_r == $past(reload_val)) && tc_r)
      else $error("expiry did not reload");
   retrig_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (retrig && mode == MD_EDGE_RETRIG && !cmd_dis && !cmd_mrst) |=> capture_r == $past(cnt_r) && pend_r && run_r)
      else $error("retrigger did not capture");
   pend_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pend_take && !cmd_load && !retrig) |=> cnt_r == $past(preset_r) && !pend_r)
      else $error("retrigger load missed");
   oneshot_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (term_hit && edge_md && !cmd_dis && !(armed_r && gate_rise)) |=> !run_r ##1 (!run_r || $past(gate_rise)))
      else $error("one-shot kept running");
   save_nodisturb_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (save_hit && !qual && !cmd_load) |=> capture_r == $past(cnt_r) && cnt_r == $past(cnt_r))
      else $error("save disturbed count");
   gate_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cmd_load && mode == MD_GATE_SEL && gate_pin) |=> cnt_r == $past(capture_r))
      else $error("gate high did not select capture");
   twoshot_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (term_hit && mode == MD_GATE_SEL && !repeat_on && second_r && !cmd_arm && !cmd_mrst) |=> !armed_r)
      else $error("two-shot did not disarm");
   expiry_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (tc_r && src_edge && !at_term) |=> !tc_r)
      else $error("expiry outlived a source period");
   flip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (tc_r && src_edge && !cmd_set && !cmd_clr) |=> flip_r != $past(flip_r))
      else $error("flip output missed expiry");
   reset_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_mrst |=> cfg_r == CFG_RST && !armed_r)
      else $error("master reset left config");
endmodule

/* verification/gcr_ext.sv */
`timescale 1ns/1ps
// Far side: one slow source pulse per request, so every edge is seen
module gcr_ext (
   input  wire logic aclk,
   input  wire logic go,
   input  wire logic gate_lvl,
   output logic      src_pin,
   output logic      gate_pin,
   output logic      busy
);
   logic [3:0] n_r = 4'h0;
   always_ff @(posedge aclk) begin
      n_r <= (go && n_r == 4'h0) ? 4'h8 : n_r - 4'(n_r != 4'h0);
   end
   assign src_pin  = n_r > 4'h4;
   assign gate_pin = gate_lvl;
   assign busy     = n_r != 4'h0;
endmodule

/* verification/test_gated_counter_reload_modes.sv */
`timescale 1ns/1ps
module test_gated_counter_reload_modes;
   import gcr_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, go = 1'b0, gl = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, cout, coe, src, gate, busy;
   int          bad_count = 0, checks_done = 0, pre, cap;
   int          mc = 0, mfl = 0, mtc = 0, marm = 0, mrt = 0, ntc = 0, lim = 0, po = 0;
   logic [2:0]  oc [4] = '{OUT_LOW, OUT_TC_HI, OUT_TC_LO, OUT_HIZ};

   gcr_counter i_gcr_counter (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .first_prescaled_freq(1'b0),
      .src_pin(src), .gate_pin(gate), .count_out(cout), .count_out_oe(coe));
   gcr_ext i_gcr_ext (.aclk(aclk), .go(go), .gate_lvl(gl), .src_pin(src), .gate_pin(gate), .busy(busy));

   initial begin
      forever #20 aclk = ~aclk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // A wait that runs out ends the run as a failure
   task automatic tmo(input int n);
      if (n >= 60) begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] e = RESP_OKAY);
      int n;
      awaddr <= a;
      wdata <= {16'h0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      tmo(n);
      chk(32'(bresp), 32'(e));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      tmo(n);
      chk(rdata, e);
      chk(32'(rresp), 32'(er));
   endtask
   // Gate is settled well before the next source edge so qualification is unambiguous
   task automatic gt(input logic v);
      gl <= v;
      repeat (4) @(posedge aclk);
   endtask
   task automatic pulse(input int q, input int rl);
      int n;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (!busy) break;
      end
      tmo(n);
      if (mrt != 0 && q != 0) begin
         mc = rl;
         mrt = 0;
      end else if (q != 0 || mtc != 0) begin
         if (mtc != 0) mfl = 1 - mfl;
         mtc = (mc == 1);
         mc = (mtc != 0) ? rl : mc - 1;
         ntc += mtc;
         if (lim != 0 && ntc == lim) marm = 0;
      end
      rd(OFF_COUNT, 32'(mc));
      chk(32'(cout), 32'(po != 0 ? mtc : mfl));
   endtask

   initial begin
      void'($urandom(90));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_CFG, 32'(CFG_RST));
      chk(32'({coe, cout}), 32'h2);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h40, 16'h1234, RESP_SLVERR);
      foreach (oc[i]) begin
         wr(OFF_CFG, 16'(oc[i]));
         repeat (3) @(posedge aclk);
         chk(32'(coe), 32'(oc[i] != OUT_HIZ));
         if (oc[i] != OUT_HIZ) chk(32'(cout), 32'(oc[i] == OUT_TC_LO));
      end
      wr(OFF_CFG, 16'h0002);
      for (int i = CMD_SET; i <= CMD_CLR; i++) begin
         wr(OFF_CMD, 16'(1 << i));
         repeat (3) @(posedge aclk);
         chk(32'(cout), 32'(i == CMD_SET));
      end
      // Preset of three or more keeps the last level-mode pulse away from an expiry
      pre = 3 + $urandom % 4;
      wr(OFF_PRESET, 16'(pre));
      wr(OFF_CFG, 16'ha0a2);
      wr(OFF_CMD, 16'h0004);
      mc = pre;
      gt(1);
      pulse(marm, pre);
      gt(0);
      wr(OFF_CMD, 16'h0001);
      marm = 1;
      pulse(0, pre);
      gt(1);
      mrt = 1;
      rd(OFF_CAPTURE, 32'(mc));
      for (int i = 0; i < 2 * pre + 3; i++) pulse(marm, pre);
      wr(OFF_CMD, 16'h0002);
      wr(OFF_CFG, 16'h0082);
      gt(0);
      wr(OFF_CMD, 16'h0005);
      mc = pre;
      lim = 2;
      ntc = 0;
      for (int i = 0; i < 2 * pre + 3; i++) pulse(marm, pre);
      lim = 0;
      cap = 2 + $urandom % 4;
      wr(OFF_CFG, 16'h00a2);
      wr(OFF_CAPTURE, 16'(cap));
      gt(1);
      wr(OFF_CMD, 16'h0004);
      rd(OFF_COUNT, 32'(cap));
      gt(0);
      wr(OFF_CMD, 16'h0004);
      rd(OFF_COUNT, 32'(pre));
      mc = pre;
      wr(OFF_CMD, 16'h0001);
      marm = 1;
      for (int i = 0; i < 12; i++) begin
         gt(i[2]);
         pulse(1, i[2] ? cap : pre);
      end
      // Edge one-shot: a disarmed gate edge is ignored, then every gate edge retriggers
      wr(OFF_CMD, 16'h0002);
      wr(OFF_CFG, 16'hc081);
      wr(OFF_CMD, 16'h0004);
      mc = pre;
      po = 1;
      gt(1);
      pulse(0, pre);
      gt(0);
      wr(OFF_CMD, 16'h0001);
      for (int r = 0; r < 2; r++) begin
         gt(1);
         mrt = 1;
         marm = 1;
         lim = 1;
         ntc = 0;
         rd(OFF_CAPTURE, 32'(mc));
         gt(0);
         for (int i = 0; i < pre + 4; i++) pulse(marm, pre);
      end
      // Save mode: a gate edge while counting only takes a snapshot
      wr(OFF_CMD, 16'h0002);
      wr(OFF_CFG, 16'hc002);
      po = 0;
      wr(OFF_CMD, 16'h0005);
      mc = pre;
      marm = 1;
      ntc = 0;
      gt(1);
      pulse(marm, pre);
      gt(0);
      gt(1);
      rd(OFF_CAPTURE, 32'(mc));
      for (int i = 0; i < pre + 2; i++) pulse(marm, pre);
      // Preset of one: the flip output moves on the second edge after the trigger
      wr(OFF_PRESET, 16'h0001);
      wr(OFF_CMD, 16'h0005);
      mc = 1;
      marm = 1;
      ntc = 0;
      gt(0);
      gt(1);
      repeat (2) pulse(marm, 1);
      wr(OFF_CMD, 16'h0020);
      rd(OFF_CFG, 32'(CFG_RST));
      rd(OFF_STATUS, 32'((mfl << 5) | (mtc << 4)));
      print_verdict();
   end
endmodule
